// file: rtl/oxrat_pkg.sv
// Shared constants, helpers and types of the octal register access link
package oxrat_pkg;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_RDREG = 8'h65;
    localparam logic [7:0] OP_WRREG = 8'h71;
    localparam logic [7:0] OP_RDMEM = 8'hee;
    localparam logic [7:0] OP_WRMEM = 8'hde;

    // ----------------------------------------------------------------
    // Frame layout and timing
    // ----------------------------------------------------------------
    localparam int CMD_EDGES      = 5;   // Command byte plus four address
    localparam int LAT_CLKS       = 3;   // Initial latency count
    localparam int LAT_MULT       = 2;   // Doubled latency always
    localparam int EDGES_PER_CLK  = 2;   // DDR: a byte per edge
    localparam int LINK_PERIOD_NS = 800;
    localparam int CORE_PERIOD_NS = 100;
    localparam int SCK_HALF_CYC   = LINK_PERIOD_NS / CORE_PERIOD_NS / 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic        WR_LATCH_RST = 1'b0;
    localparam logic [15:0] REG_RST      = 16'h0000;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_RUN  = 4'b0010,
        H_TAIL = 4'b0100,
        H_GAP  = 4'b1000
    } oxrat_hst_t;

    // Edge index of the first data byte after the dummy edges
    function automatic int data_start(input int lat);
        return CMD_EDGES + LAT_MULT * lat * EDGES_PER_CLK;
    endfunction

    function automatic logic is_read(input logic [7:0] op);
        return (op == OP_RDREG) || (op == OP_RDMEM);
    endfunction

    function automatic logic has_lat(input logic [7:0] op);
        return is_read(op) || (op == OP_WRMEM);
    endfunction

    function automatic logic has_addr(input logic [7:0] op);
        return has_lat(op) || (op == OP_WRREG);
    endfunction

endpackage

// file: rtl/oxrat_if.sv
// Link pins between host controller and device, with wire resolution
`timescale 1ns/10ps
interface oxrat_if;
    logic       cs_n;
    logic       sck;
    logic [7:0] host_dq;
    logic       host_dq_oe;
    logic [7:0] dev_dq;
    logic       dev_dq_oe;
    logic       dev_strobe;
    logic       dev_strobe_oe;
    logic [7:0] dq;
    logic       bidir_data_strobe;

    // Undriven lines read low, as a weak pull-down would give
    assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : 8'h00);
    assign bidir_data_strobe = dev_strobe_oe & dev_strobe;

    modport dev (
        input  cs_n,
        input  sck,
        input  dq,
        output dev_dq,
        output dev_dq_oe,
        output dev_strobe,
        output dev_strobe_oe
    );

    modport host (
        output cs_n,
        output sck,
        output host_dq,
        output host_dq_oe,
        input  dq,
        input  bidir_data_strobe
    );
endinterface

// file: rtl/oxrat_dev.sv
// Device end: decodes link frames, holds latch, registers and array
// Function
// [R1] Write disable blocks all later modifications
// [R2] Register read returns data after dummy latency
// [R3] Host may float data bus during dummies
// [R4] Register write data follows address immediately
// [R5] Strobe driven in command phase and read data
// [R6] Zero-latency write form targets registers only
// [R7] Strobe is no byte mask on register writes
// [R8] Array returns bytes in written order
// [R9] Word moves as A byte then B byte
// [R10] Host picks which word half is A
// [R11] Doubled initial latency always, never signalled single
// [R12] Dummy bytes ignored; read data after latency
// [R13] Write disable clears the write enable latch
// [R14] Successful register write clears the latch
// [R15] Host issues write enable before modifications
// [R16] Register data big-endian, upper byte first
`timescale 1ns/10ps
module oxrat_dev #(
    parameter int LAT_CLKS = oxrat_pkg::LAT_CLKS,
    parameter int REG_AW   = 2,
    parameter int MEM_AW   = 6
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_ce,
    oxrat_if.dev                   lnk,
    output logic                   o_wr_latch,
    output logic                   o_reg_wr,
    output logic [REG_AW-1:0]      o_reg_idx,
    output logic [15:0]            o_reg_data,
    output logic                   o_busy
);

    // ----------------------------------------------------------------
    // Frame positions
    // ----------------------------------------------------------------
    localparam int DATA0 = oxrat_pkg::data_start(LAT_CLKS);
    localparam logic [5:0] C_CMD   = 6'(oxrat_pkg::CMD_EDGES);
    localparam logic [5:0] C_LAST  = 6'(oxrat_pkg::CMD_EDGES - 1);
    localparam logic [5:0] C_WB    = 6'(oxrat_pkg::CMD_EDGES + 1);
    localparam logic [5:0] C_DATA0 = 6'(DATA0);
    localparam logic [5:0] C_RD0   = 6'(DATA0 - 1);
    localparam logic [5:0] C_SAT   = 6'h3f;

    logic              cs_s1_r;
    logic              cs_s2_r;
    logic              sck_s1_r;
    logic              sck_s2_r;
    logic              sck_d_r;
    logic [7:0]        dq_s1_r;
    logic [7:0]        dq_s2_r;
    logic              edge_w;
    logic [5:0]        cnt_r;
    logic [7:0]        op_r;
    logic [31:0]       addr_r;
    logic              wr_latch_r;
    logic [7:0]        hold_r;
    logic [MEM_AW-1:0] ptr_r;
    logic              bsel_r;
    logic              rstb_r;
    logic [7:0]        dq_r;
    logic              dq_oe_r;
    logic              stb_r;
    logic              stb_oe_r;
    logic              reg_wr_r;
    logic [15:0]       reg_data_r;
    logic [REG_AW-1:0] reg_idx_r;
    logic [15:0]       regs_r [2**REG_AW];
    logic [7:0]        mem_r  [2**MEM_AW];
    logic              rd_op_w;
    logic [REG_AW-1:0] ridx_w;
    logic              reg_fire_w;
    logic              mem_wr_w;
    logic              rd_step_w;
    logic [7:0]        rd_byte_w;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------

    // Link pins come from the host's domain: two stages each
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cs_s1_r  <= 1'b1;
            cs_s2_r  <= 1'b1;
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_d_r  <= 1'b0;
            dq_s1_r  <= 8'h00;
            dq_s2_r  <= 8'h00;
        end else if (i_ce) begin
            cs_s1_r  <= lnk.cs_n;
            cs_s2_r  <= cs_s1_r;
            sck_s1_r <= lnk.sck;
            sck_s2_r <= sck_s1_r;
            sck_d_r  <= sck_s2_r;
            dq_s1_r  <= lnk.dq;
            dq_s2_r  <= dq_s1_r;
        end
    end

    // Both clock edges carry a byte; nothing counts with select high
    assign edge_w = i_ce && !cs_s2_r && (sck_s2_r != sck_d_r);

    // ----------------------------------------------------------------
    // Command and address capture
    // ----------------------------------------------------------------

    // Opcode cleared between frames so stale reads never drive pins
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cnt_r  <= 6'h00;
            op_r   <= 8'h00;
            addr_r <= 32'h0000_0000;
        end else if (i_ce) begin
            if (cs_s2_r) begin
                cnt_r <= 6'h00;
                op_r  <= 8'h00;
            end else if (edge_w) begin
                if (cnt_r != C_SAT) begin
                    cnt_r <= cnt_r + 6'h01;
                end
                if (cnt_r == 6'h00) begin
                    op_r <= dq_s2_r;
                end else if (cnt_r < C_CMD) begin
                    addr_r <= {addr_r[23:0], dq_s2_r};
                end
            end
        end
    end

    assign rd_op_w = oxrat_pkg::is_read(op_r);
    assign ridx_w  = addr_r[REG_AW-1:0];

    // ----------------------------------------------------------------
    // Write enable latch
    // ----------------------------------------------------------------
    assign reg_fire_w = edge_w && (op_r == oxrat_pkg::OP_WRREG)
                      && (cnt_r == C_WB) && wr_latch_r;        // [R4]

    // Disable acts on the command byte itself, before any data
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wr_latch_r <= oxrat_pkg::WR_LATCH_RST;
        end else if (i_ce) begin
            if (edge_w && (cnt_r == 6'h00)
                && (dq_s2_r == oxrat_pkg::OP_WREN)) begin
                wr_latch_r <= 1'b1;
            end else if (edge_w && (cnt_r == 6'h00)
                && (dq_s2_r == oxrat_pkg::OP_WRDI)) begin
                wr_latch_r <= 1'b0;                      // [R1] [R13]
            end else if (reg_fire_w) begin
                wr_latch_r <= 1'b0;                           // [R14]
            end
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------

    // Upper byte arrives first; strobe level is never consulted
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 2**REG_AW; i++) begin
                regs_r[i] <= oxrat_pkg::REG_RST;
            end
            hold_r     <= 8'h00;
            reg_wr_r   <= 1'b0;
            reg_data_r <= 16'h0000;
            reg_idx_r  <= '0;
        end else if (i_ce) begin
            reg_wr_r <= reg_fire_w;
            if (edge_w && (cnt_r == C_CMD)) begin
                hold_r <= dq_s2_r;                      // [R4] [R16]
            end
            if (reg_fire_w) begin
                regs_r[ridx_w] <= {hold_r, dq_s2_r};    // [R7] [R16]
                reg_data_r     <= {hold_r, dq_s2_r};
                reg_idx_r      <= ridx_w;
            end
        end
    end

    // ----------------------------------------------------------------
    // Memory array
    // ----------------------------------------------------------------

    // Only the latency-bearing write form reaches the array
    assign mem_wr_w = edge_w && (op_r == oxrat_pkg::OP_WRMEM)   // [R6]
                    && (cnt_r >= C_DATA0) && wr_latch_r;  // [R12] [R1]

    // Read steps begin one edge early so a byte is ready in time
    assign rd_step_w = edge_w && rd_op_w && (cnt_r >= C_RD0); // [R12]

    // Register bytes leave big-endian; array bytes leave as stored
    always_comb begin
        if (op_r == oxrat_pkg::OP_RDREG) begin
            rd_byte_w = bsel_r ? regs_r[ridx_w][7:0]
                               : regs_r[ridx_w][15:8];   // [R2] [R16]
        end else begin
            rd_byte_w = mem_r[ptr_r];                          // [R8]
        end
    end

    // Bytes kept in arrival order, so either endianness round-trips
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ptr_r <= '0;
        end else if (i_ce) begin
            if (edge_w && (cnt_r == C_LAST)) begin
                ptr_r <= MEM_AW'({addr_r[23:0], dq_s2_r});
            end else if (mem_wr_w || (rd_step_w
                && (op_r == oxrat_pkg::OP_RDMEM))) begin
                ptr_r <= ptr_r + 1'b1;                    // [R8] [R9]
            end
        end
    end

    // Data storage carries no reset on purpose
    always_ff @(posedge i_core_clk) begin
        if (i_ce && mem_wr_w) begin
            mem_r[ptr_r] <= dq_s2_r;                      // [R8] [R9]
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------

    // Strobe high in command phase flags the doubled latency
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            dq_r     <= 8'h00;
            dq_oe_r  <= 1'b0;
            stb_r    <= 1'b0;
            stb_oe_r <= 1'b0;
            bsel_r   <= 1'b0;
            rstb_r   <= 1'b0;
        end else if (i_ce) begin
            if (cs_s2_r) begin
                dq_oe_r  <= 1'b0;
                stb_oe_r <= 1'b0;
                bsel_r   <= 1'b0;
                rstb_r   <= 1'b0;
            end else begin
                stb_oe_r <= (cnt_r < C_CMD) || rd_op_w;          // [R5]
                stb_r    <= (cnt_r < C_CMD) ? 1'b1 : rstb_r; // [R11]
                if (rd_step_w) begin
                    dq_r    <= rd_byte_w;                     // [R2]
                    dq_oe_r <= 1'b1;
                    rstb_r  <= ~rstb_r;                  // [R5] [R9]
                    bsel_r  <= ~bsel_r;
                end
            end
        end
    end

    assign lnk.dev_dq        = dq_r;
    assign lnk.dev_dq_oe     = dq_oe_r;
    assign lnk.dev_strobe    = stb_r;
    assign lnk.dev_strobe_oe = stb_oe_r;

    // ----------------------------------------------------------------
    // User side
    // ----------------------------------------------------------------
    assign o_wr_latch = wr_latch_r;
    assign o_reg_wr   = reg_wr_r;
    assign o_reg_idx  = reg_idx_r;
    assign o_reg_data = reg_data_r;
    assign o_busy     = !cs_s2_r;

endmodule

// file: rtl/oxrat_host.sv
// Host end: frames commands onto the link and buffers read words
`timescale 1ns/10ps
module oxrat_host #(
    parameter int LAT_CLKS = oxrat_pkg::LAT_CLKS,
    parameter int HALF     = oxrat_pkg::SCK_HALF_CYC,
    parameter int DEPTH    = 2
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    oxrat_if.host            lnk,
    input  wire logic        i_cmd_valid,
    output logic             o_cmd_ready,
    input  wire logic [7:0]  i_cmd_op,
    input  wire logic [31:0] i_cmd_addr,
    input  wire logic [15:0] i_cmd_wdata,
    output logic             o_rd_valid,
    input  wire logic        i_rd_ready,
    output logic [15:0]      o_rd_data,
    output logic             o_busy
);

    // ----------------------------------------------------------------
    // Constants and state
    // ----------------------------------------------------------------
    localparam int DATA0 = oxrat_pkg::data_start(LAT_CLKS);
    localparam int PW    = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW    = $clog2(DEPTH + 1);
    localparam logic [5:0] C_CMD   = 6'(oxrat_pkg::CMD_EDGES);
    localparam logic [5:0] C_DATA0 = 6'(DATA0);
    localparam logic [5:0] C_RD0   = 6'(DATA0 - 1);
    localparam logic [7:0] C_HM1   = 8'(HALF - 1);
    localparam logic [7:0] C_MID   = 8'(HALF / 2);
    localparam logic [7:0] C_TAIL  = 8'(2 * HALF);
    localparam logic [7:0] C_GAP   = 8'(HALF);

    oxrat_pkg::oxrat_hst_t state_r;
    logic [7:0]  op_r;
    logic [31:0] addr_r;
    logic [15:0] wdata_r;
    logic [5:0]  eidx_r;
    logic [5:0]  nedge_r;
    logic [5:0]  dstart_r;
    logic [7:0]  div_r;
    logic        cs_r;
    logic        sck_r;
    logic [7:0]  dq_r;
    logic        oe_r;
    logic [7:0]  tx_w;
    logic        tx_oe_w;
    logic        accept_w;
    logic [5:0]  dst_w;
    logic        stb_s1_r;
    logic        stb_s2_r;
    logic        stb_d_r;
    logic [7:0]  rdq_s1_r;
    logic [7:0]  rdq_s2_r;
    logic [7:0]  rhold_r;
    logic [1:0]  rx_n_r;
    logic        push_w;
    logic        pop_w;
    logic [15:0] fifo_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [CW-1:0] cnt_r;

    // Every frame waits for buffer room: back-pressure to the user
    assign accept_w    = o_cmd_ready && i_cmd_valid;
    assign o_cmd_ready = (state_r == oxrat_pkg::H_IDLE)
                       && (cnt_r < CW'(DEPTH));
    assign dst_w = oxrat_pkg::has_lat(i_cmd_op) ? C_DATA0 : C_CMD;

    // Byte for the next edge; write data A is the word's upper half
    always_comb begin
        tx_w = 8'h00;
        case (eidx_r)
            6'h00:   tx_w = op_r;
            6'h01:   tx_w = addr_r[31:24];
            6'h02:   tx_w = addr_r[23:16];
            6'h03:   tx_w = addr_r[15:8];
            6'h04:   tx_w = addr_r[7:0];
            default: tx_w = 8'h00;
        endcase
        if (eidx_r == dstart_r) begin
            tx_w = wdata_r[15:8];                  // [R9] [R10] [R16]
        end else if (eidx_r == dstart_r + 6'h01) begin
            tx_w = wdata_r[7:0];
        end
        tx_oe_w = (eidx_r < C_CMD) || (!oxrat_pkg::is_read(op_r)
                  && (eidx_r >= dstart_r));                   // [R3]
    end

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------

    // Data changes mid-phase, so the device samples a settled bus
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_r  <= oxrat_pkg::H_IDLE;
            op_r     <= 8'h00;
            addr_r   <= 32'h0000_0000;
            wdata_r  <= 16'h0000;
            eidx_r   <= 6'h00;
            nedge_r  <= 6'h00;
            dstart_r <= 6'h00;
            div_r    <= 8'h00;
            cs_r     <= 1'b1;
            sck_r    <= 1'b0;
            dq_r     <= 8'h00;
            oe_r     <= 1'b0;
        end else if (i_ce) begin
            case (state_r)
                oxrat_pkg::H_IDLE: begin
                    if (accept_w) begin
                        op_r     <= i_cmd_op;
                        addr_r   <= i_cmd_addr;
                        wdata_r  <= i_cmd_wdata;
                        dstart_r <= dst_w;                // [R4] [R6]
                        nedge_r  <= oxrat_pkg::has_addr(i_cmd_op)
                                  ? dst_w + 6'h02 : 6'h01;
                        eidx_r   <= 6'h00;
                        div_r    <= 8'h00;
                        cs_r     <= 1'b0;
                        dq_r     <= i_cmd_op;
                        oe_r     <= 1'b1;
                        state_r  <= oxrat_pkg::H_RUN;
                    end
                end
                oxrat_pkg::H_RUN: begin
                    div_r <= div_r + 8'h01;
                    if (div_r == C_HM1) begin
                        div_r  <= 8'h00;
                        sck_r  <= ~sck_r;
                        eidx_r <= eidx_r + 6'h01;
                        if (eidx_r + 6'h01 == nedge_r) begin
                            state_r <= oxrat_pkg::H_TAIL;
                        end
                    end else if (div_r == C_MID) begin
                        dq_r <= tx_w;
                        oe_r <= tx_oe_w;
                    end
                end
                oxrat_pkg::H_TAIL: begin
                    div_r <= div_r + 8'h01;
                    // Last byte held until the device has sampled it
                    if (div_r == C_MID) begin
                        oe_r <= 1'b0;
                    end
                    if (div_r == C_TAIL) begin
                        cs_r    <= 1'b1;
                        sck_r   <= 1'b0;
                        div_r   <= 8'h00;
                        state_r <= oxrat_pkg::H_GAP;
                    end
                end
                oxrat_pkg::H_GAP: begin
                    div_r <= div_r + 8'h01;
                    if (div_r == C_GAP) begin
                        state_r <= oxrat_pkg::H_IDLE;
                    end
                end
                default: state_r <= oxrat_pkg::H_IDLE;
            endcase
        end
    end

    assign lnk.cs_n       = cs_r;
    assign lnk.sck        = sck_r;
    assign lnk.host_dq    = dq_r;
    assign lnk.host_dq_oe = oe_r;
    assign o_busy         = (state_r != oxrat_pkg::H_IDLE);

    // ----------------------------------------------------------------
    // Read capture
    // ----------------------------------------------------------------

    // Strobe toggles before the data phase are dummy noise
    assign push_w = (stb_s2_r != stb_d_r) && !cs_r && (rx_n_r == 2'h1)
                  && oxrat_pkg::is_read(op_r) && (eidx_r >= C_RD0);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            stb_s1_r <= 1'b0;
            stb_s2_r <= 1'b0;
            stb_d_r  <= 1'b0;
            rdq_s1_r <= 8'h00;
            rdq_s2_r <= 8'h00;
            rhold_r  <= 8'h00;
            rx_n_r   <= 2'h0;
        end else if (i_ce) begin
            stb_s1_r <= lnk.bidir_data_strobe;
            stb_s2_r <= stb_s1_r;
            stb_d_r  <= stb_s2_r;
            rdq_s1_r <= lnk.dq;
            rdq_s2_r <= rdq_s1_r;
            if (state_r == oxrat_pkg::H_IDLE) begin
                rx_n_r <= 2'h0;
            end else if ((stb_s2_r != stb_d_r) && !cs_r
                && oxrat_pkg::is_read(op_r) && (eidx_r >= C_RD0)
                && (rx_n_r != 2'h2)) begin
                rhold_r <= rdq_s2_r;                       // [R9]
                rx_n_r  <= rx_n_r + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Two-entry read buffer
    // ----------------------------------------------------------------
    assign pop_w      = o_rd_valid && i_rd_ready;
    assign o_rd_valid = (cnt_r != '0);
    assign o_rd_data  = fifo_r[rp_r];

    // Pointers wrap naturally only for power-of-two depths
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                fifo_r[i] <= 16'h0000;
            end
        end else if (i_ce) begin
            if (push_w) begin
                fifo_r[wp_r] <= {rhold_r, rdq_s2_r};     // [R9] [R16]
                wp_r         <= wp_r + 1'b1;
            end
            if (pop_w) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push_w && !pop_w) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop_w && !push_w) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

endmodule

// file: verification/oxrat_chk.sv
// Link checker between host and device ends
`timescale 1ns/10ps
module oxrat_chk #(parameter int LAT_CLKS = 3) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic [7:0] dq,
    input  wire logic       host_dq_oe,
    input  wire logic       dev_dq_oe,
    input  wire logic       dev_strobe,
    input  wire logic       dev_strobe_oe
);
    localparam int DATA0 = 5 + 4 * LAT_CLKS;
    logic       sck_r;
    logic [5:0] edge_r;
    logic [7:0] op_r;
    // Edge count and command byte; edges counted here lead the device
    always_ff @(posedge i_core_clk) begin
        sck_r <= sck;
        if (!i_rst_n || cs_n) edge_r <= 6'h00;
        else if (sck != sck_r) edge_r <= edge_r + 6'h01;
        if (!cs_n && sck != sck_r && edge_r == 6'h00) op_r <= dq;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence quiet_s;
        cs_n [*4];
    endsequence
    bus_single_a: assert property (!(host_dq_oe && dev_dq_oe))
        else $error("both ends drive data");
    dev_release_a: assert property (quiet_s |-> !dev_dq_oe && !dev_strobe_oe)
        else $error("device drives while deselected");
    sck_idle_a: assert property (cs_n && $past(cs_n) |-> $stable(sck))
        else $error("link clock runs outside frame");
    strobe_cmd_a: assert property (!cs_n && edge_r != 6'h00 && edge_r < 6'h04
        |-> dev_strobe_oe && dev_strobe)
        else $error("strobe not high in command phase");
    strobe_data_a: assert property (dev_dq_oe |-> dev_strobe_oe)
        else $error("read data without strobe");
    dummy_quiet_a: assert property (!cs_n && edge_r < DATA0 - 1
        |-> !dev_dq_oe)
        else $error("device drives before latency");
    host_float_a: assert property (op_r == oxrat_pkg::OP_RDREG && !cs_n
        && edge_r > 6'h06 && edge_r < 6'h0f |-> !host_dq_oe)
        else $error("host drives in dummy cycles");
    wr_direct_a: assert property (op_r == oxrat_pkg::OP_WRREG && !cs_n
        && edge_r == 6'h06 |-> host_dq_oe)
        else $error("register write data not immediate");
endmodule

// file: verification/test_octal_xspi_register_access_txn.sv
// Bench joining host and device ends over the link
`timescale 1ns/10ps
module test_octal_xspi_register_access_txn;
    logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0, pop = 1'b0;
    logic [7:0]  op = 8'h00;
    logic [31:0] addr = 32'h0;
    logic [15:0] wd = 16'h0, rd_data, reg_data;
    logic        rdy, rd_valid, h_busy, d_busy, wr_latch, reg_wr;
    logic [1:0]  reg_idx;
    int          fail_count = 0, checks = 0, wr_pulses = 0;
    oxrat_if lnk ();
    oxrat_host u_oxrat_host (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
        .lnk(lnk.host), .i_cmd_valid(vld), .o_cmd_ready(rdy), .i_cmd_op(op),
        .i_cmd_addr(addr), .i_cmd_wdata(wd), .o_rd_valid(rd_valid),
        .i_rd_ready(pop), .o_rd_data(rd_data), .o_busy(h_busy));
    oxrat_dev u_oxrat_dev (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
        .lnk(lnk.dev), .o_wr_latch(wr_latch), .o_reg_wr(reg_wr),
        .o_reg_idx(reg_idx), .o_reg_data(reg_data), .o_busy(d_busy));
    oxrat_chk #(.LAT_CLKS(oxrat_pkg::LAT_CLKS)) u_oxrat_chk (
        .i_core_clk(clk), .i_rst_n(rst_n), .cs_n(lnk.cs_n), .sck(lnk.sck),
        .dq(lnk.dq), .host_dq_oe(lnk.host_dq_oe), .dev_dq_oe(lnk.dev_dq_oe),
        .dev_strobe(lnk.dev_strobe), .dev_strobe_oe(lnk.dev_strobe_oe));
    // Core clock, 100 ns
    always #50 clk = ~clk;
    // Register write pulses at the user port, one per cycle high
    always @(posedge clk) if (reg_wr === 1'b1) wr_pulses++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One frame; request held until ready seen, then wait for idle
    task automatic send(input logic [7:0] o, input logic [31:0] a,
                        input logic [15:0] d);
        @(posedge clk);
        op <= o;
        addr <= a;
        wd <= d;
        vld <= 1'b1;
        @(posedge clk);
        repeat (400) if (rdy !== 1'b1) @(posedge clk);
        chk(rdy, 1'b1);
        vld <= 1'b0;
        repeat (2) @(posedge clk);
        repeat (400) if (h_busy !== 1'b0 || d_busy !== 1'b0) @(posedge clk);
        chk({h_busy, d_busy}, 16'h0000);
    endtask
    task automatic take(input logic [15:0] exp);
        @(posedge clk);
        repeat (400) if (rd_valid !== 1'b1) @(posedge clk);
        chk(rd_valid, 1'b1);
        chk(rd_data, exp);
        pop <= 1'b1;
        @(posedge clk);
        pop <= 1'b0;
    endtask
    task automatic t_regs;
        send(oxrat_pkg::OP_WREN, 32'h0, 16'h0);
        chk(wr_latch, 1'b1);
        send(oxrat_pkg::OP_WRREG, 32'h2, 16'ha53c);
        chk(reg_data, 16'ha53c);
        chk(reg_idx, 2'h2);
        chk(wr_latch, 1'b0);
        send(oxrat_pkg::OP_RDREG, 32'h2, 16'h0);
        take(16'ha53c);
        send(oxrat_pkg::OP_WREN, 32'h0, 16'h0);
        send(oxrat_pkg::OP_WRDI, 32'h0, 16'h0);
        chk(wr_latch, 1'b0);
        send(oxrat_pkg::OP_WRREG, 32'h2, 16'h1111);
        send(oxrat_pkg::OP_RDREG, 32'h2, 16'h0);
        take(16'ha53c);
        chk(16'(wr_pulses), 16'h0001);
    endtask
    // Two reads left unpopped fill the buffer before draining
    task automatic t_mem;
        send(oxrat_pkg::OP_WREN, 32'h0, 16'h0);
        send(oxrat_pkg::OP_WRMEM, 32'h4, 16'h1234);
        send(oxrat_pkg::OP_WRMEM, 32'h8, 16'h3412);
        send(oxrat_pkg::OP_RDMEM, 32'h4, 16'h0);
        send(oxrat_pkg::OP_RDMEM, 32'h8, 16'h0);
        chk(rdy, 1'b0);
        take(16'h1234);
        take(16'h3412);
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_mem();
        print_verdict();
    end
    // Watchdog, well past the expected run
    initial begin
        #1000000;
        fail_count++;
        print_verdict();
    end
endmodule
